// ---- verilog/cmp_skip_pkg.sv ----
// constants, states and encodings shared by the compare-and-skip decoder
// Behaviour
// - opcode 0110 010 plus access bit, file address low byte: skip if byte greater
// - opcode 0110 000 plus access bit, file address low byte: skip if byte less
// - compare is unsigned subtraction of working register from file byte, decides skip only
// - on skip the fetched next instruction is discarded and a no-op cycle runs
// - one cycle plain, two with skip, three when skipped word is two-word
// - file address spans 0 to 255; access bit is 0 or 1
// - access bit 0 uses access bank; 1 takes upper address from bank select
// - extended set and access bit 0: indexed literal offset for addresses up to 5Fh
package cmp_skip_pkg;
    // instruction word fields
    localparam int OPCODE_MSB = 15;
    localparam int OPCODE_LSB = 9;
    localparam int ACCESS_BIT = 8;
    localparam int FILE_MSB = 7;
    localparam logic [6:0] OPCODE_GREATER = 7'h32;
    localparam logic [6:0] OPCODE_LESS = 7'h30;
    // operand address map
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [7:0] INDEX_LIMIT = 8'h5f;
    // cycle counts per outcome
    localparam int CYCLES_PLAIN = 1;
    localparam int CYCLES_SKIP = 2;
    localparam int CYCLES_SKIP_TWO_WORD = 3;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EXEC,
        ST_NOP1,
        ST_NOP2
    } phase_e;
endpackage

// ---- verilog/operand_if.sv ----
// operand address and compare signals between the decoder and its operand unit
`timescale 1ns/1ps
`default_nettype none
interface operand_if #(parameter int BANK_W = 4);
    localparam int AW = BANK_W + 8;
    logic [7:0] file_addr;
    logic access;
    logic [BANK_W-1:0] bank_select_register;
    logic ext_enable;
    logic [AW-1:0] index_base;
    logic [AW-1:0] data_addr;
    logic [7:0] file_byte;
    logic [7:0] working_register;
    logic greater;
    logic less;
    modport decoder (
        output file_addr, access, bank_select_register, ext_enable, index_base,
        output file_byte, working_register,
        input data_addr, greater, less
    );
    modport unit (
        input file_addr, access, bank_select_register, ext_enable, index_base,
        input file_byte, working_register,
        output data_addr, greater, less
    );
endinterface
`default_nettype wire

// ---- verilog/operand_unit.sv ----
// operand address generation and unsigned compare, no state
`timescale 1ns/1ps
`default_nettype none
module operand_unit #(
    parameter int BANK_W = 4
) (
    operand_if.unit opif
);
    localparam int AW = BANK_W + 8;
    logic [8:0] diff;

    // address select: bank select, indexed offset, or access bank halves
    always_comb begin
        if (opif.access) begin
            opif.data_addr = {opif.bank_select_register, opif.file_addr};
        end else if (opif.ext_enable && (opif.file_addr <= cmp_skip_pkg::INDEX_LIMIT)) begin
            opif.data_addr = AW'(opif.index_base + AW'(opif.file_addr));
        end else if (opif.file_addr < cmp_skip_pkg::ACCESS_SPLIT) begin
            opif.data_addr = {{BANK_W{1'b0}}, opif.file_addr};
        end else begin
            opif.data_addr = {{BANK_W{1'b1}}, opif.file_addr};
        end
    end

    // borrow of the 9-bit difference gives less; nonzero without borrow gives greater
    always_comb begin
        diff = {1'b0, opif.file_byte} - {1'b0, opif.working_register};
        opif.less = diff[8];
        opif.greater = !diff[8] && (diff[7:0] != 8'h00);
    end
endmodule // operand_unit
`default_nettype wire

// ---- verilog/compare_skip_instructions.sv ----
// compare-and-skip decoder and sequencer: one clock is one instruction cycle
`timescale 1ns/1ps
`default_nettype none
module compare_skip_instructions #(
    parameter int BANK_W = 4
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_insn_valid,
    input wire logic [15:0] i_insn,
    input wire logic [7:0] i_working_register,
    input wire logic [BANK_W-1:0] i_bank_select_register,
    input wire logic i_ext_enable,
    input wire logic [BANK_W+7:0] i_index_base,
    input wire logic [7:0] i_file_data,
    input wire logic i_next_two_word,
    output logic o_busy,
    output logic o_data_rd,
    output logic [BANK_W+7:0] o_data_addr,
    output logic o_skip,
    output logic o_nop_cycle,
    output logic o_done
);
    localparam int AW = BANK_W + 8;

    // bank select wider than 8 bits has no meaning in the address space
    if (BANK_W < 1 || BANK_W > 8) begin : g_bad_width
        $error("BANK_W must lie between 1 and 8");
    end

    typedef struct packed {
        cmp_skip_pkg::phase_e phase;
        logic [7:0] working;
        logic is_greater;
        logic two_word;
        logic [AW-1:0] addr;
        logic rd;
        logic skip;
        logic nop;
        logic busy;
        logic done;
    } state_s;

    state_s s;
    state_s next_s;
    logic [6:0] opcode;
    logic match_gt;
    logic match_lt;
    logic hit;

    operand_if #(.BANK_W(BANK_W)) opif ();

    operand_unit #(.BANK_W(BANK_W)) u_operand (
        .opif(opif)
    );

    // decode the upper opcode bits; access bit and file byte follow
    assign opcode = i_insn[cmp_skip_pkg::OPCODE_MSB:cmp_skip_pkg::OPCODE_LSB];
    assign match_gt = (opcode == cmp_skip_pkg::OPCODE_GREATER);
    assign match_lt = (opcode == cmp_skip_pkg::OPCODE_LESS);

    // operand fields straight from the word; full 0..255 range, single access bit
    assign opif.file_addr = i_insn[cmp_skip_pkg::FILE_MSB:0];
    assign opif.access = i_insn[cmp_skip_pkg::ACCESS_BIT];
    assign opif.bank_select_register = i_bank_select_register;
    assign opif.ext_enable = i_ext_enable;
    assign opif.index_base = i_index_base;
    // compare uses the working register captured at decode, not the live one
    assign opif.file_byte = i_file_data;
    assign opif.working_register = s.working;
    assign hit = s.is_greater ? opif.greater : opif.less;

    // sequencer: decode, execute, then zero to two no-op cycles
    always_comb begin
        next_s = s;
        next_s.skip = 1'b0;
        next_s.done = 1'b0;
        next_s.rd = 1'b0;
        unique case (s.phase)
            cmp_skip_pkg::ST_IDLE: begin
                next_s.nop = 1'b0;
                if (i_insn_valid && (match_gt || match_lt)) begin
                    next_s.phase = cmp_skip_pkg::ST_EXEC;
                    next_s.working = i_working_register;
                    next_s.is_greater = match_gt;
                    next_s.addr = opif.data_addr;
                    next_s.rd = 1'b1;
                    next_s.busy = 1'b1;
                end
            end
            cmp_skip_pkg::ST_EXEC: begin
                if (hit) begin
                    // the fetched word is flushed and replaced by a no-op
                    next_s.skip = 1'b1;
                    next_s.nop = 1'b1;
                    next_s.two_word = i_next_two_word;
                    next_s.phase = cmp_skip_pkg::ST_NOP1;
                end else begin
                    next_s.done = 1'b1;
                    next_s.busy = 1'b0;
                    next_s.phase = cmp_skip_pkg::ST_IDLE;
                end
            end
            cmp_skip_pkg::ST_NOP1: begin
                if (s.two_word) begin
                    // second word of a skipped two-word instruction is a no-op too
                    next_s.nop = 1'b1;
                    next_s.phase = cmp_skip_pkg::ST_NOP2;
                end else begin
                    next_s.nop = 1'b0;
                    next_s.done = 1'b1;
                    next_s.busy = 1'b0;
                    next_s.phase = cmp_skip_pkg::ST_IDLE;
                end
            end
            cmp_skip_pkg::ST_NOP2: begin
                next_s.nop = 1'b0;
                next_s.done = 1'b1;
                next_s.busy = 1'b0;
                next_s.phase = cmp_skip_pkg::ST_IDLE;
            end
        endcase
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s <= '0;
        end else if (i_ce) begin
            s <= next_s;
        end
    end

    // outputs straight from the state register; there is no write port at all
    assign o_busy = s.busy;
    assign o_data_rd = s.rd;
    assign o_data_addr = s.addr;
    assign o_skip = s.skip;
    assign o_nop_cycle = s.nop;
    assign o_done = s.done;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_nrst);

    // greater opcode leads to a read and the greater compare
    chk_greater_decode: assert property (
        (i_ce && s.phase == cmp_skip_pkg::ST_IDLE && i_insn_valid
            && i_insn[15:9] == 7'h32)
        |=> (o_data_rd && s.is_greater && o_busy)
    ) else $error("greater opcode not decoded");

    // less opcode leads to a read and the less compare
    chk_less_decode: assert property (
        (i_ce && s.phase == cmp_skip_pkg::ST_IDLE && i_insn_valid
            && i_insn[15:9] == 7'h30)
        |=> (o_data_rd && !s.is_greater && o_busy)
    ) else $error("less opcode not decoded");

    // unsigned compare against the captured working register
    chk_unsigned_compare: assert property (
        (opif.greater == (i_file_data > s.working))
        && (opif.less == (i_file_data < s.working))
    ) else $error("compare result wrong");

    // a skip comes with a no-op cycle while still busy
    chk_skip_discard: assert property (
        (i_ce && s.phase == cmp_skip_pkg::ST_EXEC && hit)
        |=> (o_skip && o_nop_cycle && o_busy && !o_done)
    ) else $error("skip did not discard");

    // no skip finishes at the execute cycle
    chk_plain_done: assert property (
        (i_ce && s.phase == cmp_skip_pkg::ST_EXEC && !hit)
        |=> (o_done && !o_busy && !o_skip)
    ) else $error("plain compare not one cycle");

    // skipped two-word instruction costs a second no-op cycle
    chk_two_word_nop: assert property (
        (i_ce && s.phase == cmp_skip_pkg::ST_EXEC && hit && i_next_two_word) ##1 i_ce
        |=> (o_nop_cycle && !o_done && !o_skip)
    ) else $error("two-word skip too short");

    // access bit 1 takes the bank select as upper address bits
    chk_bank_select: assert property (
        opif.access |-> (opif.data_addr[AW-1:8] == i_bank_select_register)
    ) else $error("bank select not used");

    // indexed literal offset when extended set is on and offset is low
    chk_indexed_offset: assert property (
        (!opif.access && i_ext_enable && opif.file_addr <= 8'h5f)
        |-> (opif.data_addr == AW'(i_index_base + AW'(opif.file_addr)))
    ) else $error("indexed offset address wrong");

    // one read per instruction, never repeated
    chk_single_read: assert property (
        (o_data_rd && i_ce) |=> !o_data_rd
    ) else $error("repeated operand read");

    // access bank: low page below the split, top page at and above it
    chk_access_bank: assert property (
        (!opif.access && !(i_ext_enable && opif.file_addr <= cmp_skip_pkg::INDEX_LIMIT))
        |-> (opif.data_addr == {(opif.file_addr < cmp_skip_pkg::ACCESS_SPLIT)
            ? {BANK_W{1'b0}} : {BANK_W{1'b1}}, opif.file_addr})
    ) else $error("access bank address wrong");

    // single-word skipped instruction: one no-op cycle, then done
    chk_skip_one_nop: assert property (
        (i_ce && s.phase == cmp_skip_pkg::ST_EXEC && hit && !i_next_two_word) ##1 i_ce
        |=> (o_done && !o_nop_cycle && !o_busy)
    ) else $error("single skip not two cycles");

    // a fetched word offered while busy is ignored, never read again
    chk_no_reaccept: assert property (
        (i_ce && s.phase != cmp_skip_pkg::ST_IDLE) |=> !o_data_rd
    ) else $error("instruction accepted while busy");

    // done pulse ends the busy span with the sequencer back at idle
    chk_done_idle: assert property (
        o_done |-> (!o_busy && s.phase == cmp_skip_pkg::ST_IDLE)
    ) else $error("done while still busy");

    // clock enable low holds every state bit, outputs included
    chk_ce_freeze: assert property (
        !i_ce |=> (s == $past(s))
    ) else $error("state moved while clock enable low");
endmodule // compare_skip_instructions
`default_nettype wire

// ---- verification/data_memory_model.sv ----
// data memory model answering operand reads of the compare decoder
`timescale 1ns/1ps
`default_nettype none
module data_memory_model (
    input wire logic i_ref_clk,
    input wire logic i_rd,
    input wire logic [11:0] i_addr,
    output logic [7:0] o_data
);
    logic [7:0] last = 8'h00;
    logic [7:0] byte_at;
    // contents follow the address, so a wrong bank gives a wrong byte
    assign byte_at = i_addr[7:0] ^ {i_addr[11:8], 4'h5};
    // outside a read show the inverse, so a late sample never matches
    assign o_data = i_rd ? byte_at : ~last;
    // remember the last byte handed out
    always_ff @(posedge i_ref_clk) begin
        if (i_rd) begin
            last <= byte_at;
        end
    end
endmodule // data_memory_model
`default_nettype wire

// ---- verification/compare_skip_instructions_tb.sv ----
// self-checking bench for the compare-and-skip decoder
`timescale 1ns/1ps
`default_nettype none
module compare_skip_instructions_tb;
    logic i_ref_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_ce = 1'b1;
    logic i_insn_valid = 1'b0;
    logic [15:0] i_insn = 16'h0000;
    logic [7:0] w = 8'h00;
    logic [3:0] bank = 4'h0;
    logic ext = 1'b0;
    logic [11:0] base = 12'h000;
    logic two = 1'b0;
    logic [7:0] fdata;
    logic o_busy, o_data_rd, o_skip, o_nop_cycle, o_done;
    logic [11:0] o_data_addr;
    int fails = 0;
    int compares = 0;
    // 25 MHz clock
    always #20 i_ref_clk = ~i_ref_clk;
    compare_skip_instructions #(.BANK_W(4)) i_dut (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
        .i_ce(i_ce), .i_insn_valid(i_insn_valid), .i_insn(i_insn), .i_working_register(w),
        .i_bank_select_register(bank), .i_ext_enable(ext), .i_index_base(base),
        .i_file_data(fdata), .i_next_two_word(two), .o_busy(o_busy), .o_data_rd(o_data_rd),
        .o_data_addr(o_data_addr), .o_skip(o_skip), .o_nop_cycle(o_nop_cycle), .o_done(o_done));
    data_memory_model i_mem (.i_ref_clk(i_ref_clk), .i_rd(o_data_rd), .i_addr(o_data_addr),
        .o_data(fdata));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // one instruction: counts cycles, skips and no-ops until done
    task automatic ex(input logic [15:0] ins, input logic [7:0] wv, input logic [3:0] bv,
            input logic xv, input logic [11:0] bs, input logic tw, input logic [11:0] ea);
        int n;
        int nops;
        int skips;
        logic [7:0] fb;
        logic sk;
        n = 1;
        nops = 0;
        skips = 0;
        fb = ea[7:0] ^ {ea[11:8], 4'h5};
        sk = (ins[15:9] == cmp_skip_pkg::OPCODE_GREATER) ? (fb > wv) : (fb < wv);
        @(posedge i_ref_clk);
        i_insn_valid <= 1'b1;
        i_insn <= ins;
        w <= wv;
        bank <= bv;
        ext <= xv;
        base <= bs;
        two <= tw;
        @(posedge i_ref_clk);
        i_insn_valid <= 1'b0;
        #1;
        check(o_data_rd, 1'b1);
        check(o_data_addr, ea);
        check(o_busy, 1'b1);
        while (o_done !== 1'b1) begin
            if (n > 8) begin
                fails++;
                finish_test();
            end
            @(posedge i_ref_clk);
            #1;
            n++;
            nops += (o_nop_cycle === 1'b1) ? 1 : 0;
            skips += (o_skip === 1'b1) ? 1 : 0;
        end
        check(n, sk ? (tw ? 4 : 3) : 2);
        check(skips, sk);
        check(nops, sk ? (tw ? 2 : 1) : 0);
        check(o_busy, 1'b0);
    endtask
    // byte above, equal, and unsigned-large byte
    task automatic t_greater;
        ex(16'h6434, 8'h30, 4'h0, 1'b0, 12'h000, 1'b0, 12'h034);
        ex(16'h6434, 8'h31, 4'h0, 1'b0, 12'h000, 1'b0, 12'h034);
        ex(16'h65f5, 8'h10, 4'h0, 1'b0, 12'h000, 1'b0, 12'h0f5);
    endtask
    task automatic t_less;
        ex(16'h6034, 8'h32, 4'h0, 1'b0, 12'h000, 1'b0, 12'h034);
        ex(16'h6034, 8'h31, 4'h0, 1'b0, 12'h000, 1'b0, 12'h034);
        ex(16'h61f5, 8'h10, 4'h0, 1'b0, 12'h000, 1'b0, 12'h0f5);
        ex(16'h61f5, 8'hff, 4'h0, 1'b0, 12'h000, 1'b0, 12'h0f5);
    endtask
    // next word is the first of a two-word instruction, skipped or kept
    task automatic t_two_word;
        ex(16'h6434, 8'h00, 4'h0, 1'b0, 12'h000, 1'b1, 12'h034);
        ex(16'h6034, 8'hff, 4'h0, 1'b0, 12'h000, 1'b1, 12'h034);
        ex(16'h6434, 8'hff, 4'h0, 1'b0, 12'h000, 1'b1, 12'h034);
    endtask
    // bank select, indexed offset with wrap, access bank halves
    task automatic t_address;
        ex(16'h6134, 8'h00, 4'h9, 1'b1, 12'h000, 1'b0, 12'h934);
        ex(16'h6020, 8'h00, 4'h9, 1'b1, 12'h7f0, 1'b0, 12'h810);
        ex(16'h605f, 8'h00, 4'h0, 1'b1, 12'hff0, 1'b0, 12'h04f);
        ex(16'h6060, 8'h00, 4'h0, 1'b1, 12'h7f0, 1'b0, 12'hf60);
        ex(16'h605f, 8'h00, 4'h0, 1'b0, 12'h7f0, 1'b0, 12'h05f);
        ex(16'h6100, 8'h00, 4'hf, 1'b0, 12'h000, 1'b0, 12'hf00);
        ex(16'h61ff, 8'h00, 4'h0, 1'b0, 12'h000, 1'b0, 12'h0ff);
    endtask
    // foreign opcode ignored, valid held while busy is not taken twice
    task automatic t_refuse;
        int n;
        n = 0;
        @(posedge i_ref_clk);
        i_insn_valid <= 1'b1;
        i_insn <= 16'h6234;
        ext <= 1'b0;
        @(posedge i_ref_clk);
        i_insn <= 16'h6434;
        w <= 8'hff;
        #1;
        check(o_data_rd, 1'b0);
        @(posedge i_ref_clk);
        #1;
        check(o_data_rd, 1'b1);
        @(posedge i_ref_clk);
        i_insn_valid <= 1'b0;
        #1;
        n += (o_data_rd === 1'b1) ? 1 : 0;
        repeat (3) begin
            @(posedge i_ref_clk);
            #1;
            n += (o_data_rd === 1'b1) ? 1 : 0;
        end
        check(n, 0);
    endtask
    // clock enable low holds a skip in flight; a mid-run reset clears everything
    task automatic t_freeze;
        @(posedge i_ref_clk);
        i_insn_valid <= 1'b1;
        i_insn <= 16'h6434;
        w <= 8'h00;
        ext <= 1'b0;
        two <= 1'b0;
        @(posedge i_ref_clk);
        i_insn_valid <= 1'b0;
        @(posedge i_ref_clk);
        i_ce <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        i_ce <= 1'b1;
        #1;
        check({o_busy, o_skip, o_nop_cycle, o_done}, 4'he);
        @(posedge i_ref_clk);
        #1;
        check({o_busy, o_skip, o_nop_cycle, o_done}, 4'h1);
        @(posedge i_ref_clk);
        i_insn_valid <= 1'b1;
        @(posedge i_ref_clk);
        i_insn_valid <= 1'b0;
        i_nrst <= 1'b0;
        #1;
        check({o_busy, o_data_rd, o_skip, o_nop_cycle, o_done, o_data_addr}, 17'h0);
        repeat (2) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        @(posedge i_ref_clk);
        #1;
        check({o_busy, o_data_rd, o_done, o_data_addr}, 15'h0);
    endtask
    initial begin
        repeat (6) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        t_greater();
        t_less();
        t_two_word();
        t_address();
        t_refuse();
        t_freeze();
        finish_test();
    end
endmodule // compare_skip_instructions_tb
`default_nettype wire
